// ### include/pdc_defines.svh
// Register offsets, field positions, reset values and timing counts of the down-counter timer core
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

// Register byte offsets on the APB
`define PDC_CTRL_OFS 12'h000
`define PDC_STAT_OFS 12'h004
`define PDC_PREL_OFS 12'h008
`define PDC_MATCH_OFS 12'h00C
`define PDC_COUNT_OFS 12'h010

// Control register fields
`define PDC_CTRL_RUN 0
`define PDC_CTRL_PCE 1
`define PDC_CTRL_EXT 2
`define PDC_CTRL_PSC 3
`define PDC_CTRL_MODE_LO 4
`define PDC_CTRL_MODE_HI 6
`define PDC_CTRL_OC_LO 8
`define PDC_CTRL_OC_HI 9
`define PDC_CTRL_IEN_LO 16
`define PDC_CTRL_IEN_HI 22

// Status register fields: sticky events in the low byte, levels above
`define PDC_EV_TIMEOUT 0
`define PDC_EV_MATCH 1
`define PDC_EV_PSC_WRAP 2
`define PDC_EV_START 3
`define PDC_EV_RELOAD 4
`define PDC_EV_WAVE 5
`define PDC_EV_EXT_EDGE 6
`define PDC_ST_COM 8
`define PDC_ST_RUNNING 9
`define PDC_ST_OUT 10
`define PDC_ST_EXT_LVL 11

// Reset values
`define PDC_PSC_RST 8'hFF
`define PDC_CNT_RST 16'h0000
`define PDC_CTRL_RST 32'h0000_0000
`define PDC_PREL_RST 16'h0000
`define PDC_MATCH_RST 16'h0000

// Timing: the internal clock runs at half the bus clock
`define PDC_PCLK_MHZ 40
`define PDC_HALF_DIV 2

`endif

// ### include/pdc_pkg.sv
// Types shared by the down-counter timer core
package pdc_pkg;
  // Operating modes of the counter
  typedef enum logic [2:0] {
    PDC_MODE_CAPCMP = 3'h0,
    PDC_MODE_SQUARE = 3'h1,
    PDC_MODE_OTHER2 = 3'h2,
    PDC_MODE_OTHER3 = 3'h3,
    PDC_MODE_OTHER4 = 3'h4,
    PDC_MODE_OTHER5 = 3'h5,
    PDC_MODE_OTHER6 = 3'h6,
    PDC_MODE_OTHER7 = 3'h7
  } pdc_mode_t;

  // Waveform output reaction to a counter event
  typedef enum logic [1:0] {
    PDC_OC_NONE = 2'h0,
    PDC_OC_TOGGLE = 2'h1,
    PDC_OC_ZERO = 2'h2,
    PDC_OC_ONE = 2'h3
  } pdc_oc_t;

  // Control register image
  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic [6:0] irq_en;
    logic [5:0] rsvd_mid;
    pdc_oc_t oc;
    logic rsvd_lo;
    pdc_mode_t mode;
    logic cnt_from_psc;
    logic ext_clk_sel;
    logic prescale_count_enable;
    logic soft_run_control;
  } pdc_ctrl_t;

  // Counter side state seen by the bus
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] psc;
  } pdc_cnt_t;

  // Load sequencing states, one-hot
  typedef enum logic [2:0] {
    PDC_IDLE = 3'b001,
    PDC_ARMED = 3'b010,
    PDC_RUN = 3'b100
  } pdc_state_t;
endpackage

// ### hw/pdc_sync.sv
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module pdc_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level in and out
  input wire logic d_in,
  output logic q_out
);
  logic meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

// ### hw/pdc_downcnt.sv
// Parameterised loadable down counter advanced by a one-cycle tick
`timescale 1ns/1ps
module pdc_downcnt #(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic hold,
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // State
  output logic [W-1:0] count,
  output logic wrap
);
  wire logic [W-1:0] dec = count - {{(W-1){1'b0}}, 1'b1};

  // Wrap marks a tick taken while the count sits at zero
  assign wrap = tick && !hold && !load && (count == '0);

  // Hold returns to the reset value; load wins over decrement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= RST;
    end else if (hold) begin
      count <= RST;
    end else if (tick && load) begin
      count <= load_val;
    end else if (tick) begin
      count <= dec;
    end
  end
endmodule

// ### hw/pdc_timer.sv
// Timer core: clock selection, 8-bit prescaler, 16-bit down counter, compare and APB registers
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pdc_defines.svh"

//////////////////////////////////////////////////////////////////////////////
module pdc_timer
  import pdc_pkg::*;
(
  // System clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins
  input wire logic ext_count_clock_in,
  output logic waveform_out,
  // Masked interrupt conditions
  output logic [6:0] irq_req
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  pdc_ctrl_t ctrl_reg;
  logic [15:0] first_reload_value;
  logic [15:0] match_value_register;
  logic [6:0] event_reg;
  logic [6:0] event_next;
  logic com_reg;
  logic wave_reg;
  logic half_clk_reg;
  logic ext_prev_reg;
  logic match_prev_reg;
  pdc_state_t state_reg;
  pdc_state_t state_next;
  pdc_cnt_t cnt;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire logic setup_phase = psel && !penable;
  wire logic access_phase = psel && penable;
  wire logic hit_ctrl = (paddr == `PDC_CTRL_OFS);
  wire logic hit_stat = (paddr == `PDC_STAT_OFS);
  wire logic hit_prel = (paddr == `PDC_PREL_OFS);
  wire logic hit_match = (paddr == `PDC_MATCH_OFS);
  wire logic hit_count = (paddr == `PDC_COUNT_OFS);
  wire logic hit_any = hit_ctrl || hit_stat || hit_prel || hit_match || hit_count;
  wire logic wr_en = access_phase && pwrite && hit_any;
  wire logic [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Slave answers in the first access cycle; no wait states
  assign pready = 1'b1;
  assign pslverr = access_phase && !hit_any;

  //////////////////////////////////////////////////////////////////////////////
  // Clock selection and synchronisation
  logic ext_lvl;

  pdc_sync u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d_in(ext_count_clock_in),
    .q_out(ext_lvl)
  );

  // Half-rate internal clock as a toggling level, falling when it leaves 1
  wire logic half_fall = half_clk_reg;
  wire logic ext_fall = ext_prev_reg && !ext_lvl;
  wire logic sel_fall = ctrl_reg.ext_clk_sel ? ext_fall : half_fall;

  // Timer enable: both control bits must be set
  wire logic timer_en = ctrl_reg.prescale_count_enable && ctrl_reg.soft_run_control;

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter
  logic psc_wrap;
  wire logic cnt_tick = timer_en && (ctrl_reg.cnt_from_psc ? psc_wrap : sel_fall);
  // Idle or armed: the next counter tick is the first one after enable and loads
  wire logic first_edge = (state_reg != PDC_RUN);
  wire logic cnt_zero = (cnt.count == 16'h0000);
  wire logic cnt_load = first_edge || cnt_zero;

  // Prescaler counts falling edges of the selected clock and wraps FF..0..FF
  pdc_downcnt #(
    .W(8),
    .RST(`PDC_PSC_RST)
  ) u_psc (
    .pclk(pclk),
    .presetn(presetn),
    .hold(!timer_en),
    .tick(timer_en && sel_fall),
    .load(1'b0),
    .load_val(`PDC_PSC_RST),
    .count(cnt.psc),
    .wrap(psc_wrap)
  );

  // Counter held at zero while disabled, loaded on its first edge after enable
  pdc_downcnt #(
    .W(16),
    .RST(`PDC_CNT_RST)
  ) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .hold(!timer_en),
    .tick(cnt_tick),
    .load(cnt_load),
    .load_val(first_reload_value),
    .count(cnt.count),
    .wrap()
  );

  //////////////////////////////////////////////////////////////////////////////
  // Load sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PDC_IDLE: begin
        // A tick in the enabling cycle already loads, so skip the armed wait
        if (timer_en && cnt_tick) begin
          state_next = PDC_RUN;
        end else if (timer_en) begin
          state_next = PDC_ARMED;
        end
      end
      PDC_ARMED: begin
        if (!timer_en) begin
          state_next = PDC_IDLE;
        end else if (cnt_tick) begin
          state_next = PDC_RUN;
        end
      end
      PDC_RUN: begin
        if (!timer_en) begin
          state_next = PDC_IDLE;
        end
      end
      default: begin
        state_next = PDC_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter events
  wire logic running = (state_reg != PDC_IDLE);
  // Timeout is a decrement that lands on zero after the first load
  wire logic timeout_ev = cnt_tick && (state_reg == PDC_RUN) && (cnt.count == 16'h0001);
  // Comparator watches the live count; a new equality is one event
  wire logic match_now = running && (cnt.count == match_value_register);
  wire logic match_ev = match_now && !match_prev_reg;
  // Reload is a tick that finds zero; load has priority there, so the counter's wrap stays quiet
  wire logic reload_ev = cnt_tick && cnt_zero && (state_reg == PDC_RUN);
  wire logic mode_capcmp = (ctrl_reg.mode == PDC_MODE_CAPCMP);
  wire logic mode_square = (ctrl_reg.mode == PDC_MODE_SQUARE);
  // Match drives the output only in compare mode; timeout drives it in square mode
  wire logic wave_ev = (mode_capcmp && match_ev) || (mode_square && timeout_ev);
  logic wave_next;

  always_comb begin
    wave_next = wave_reg;
    if (wave_ev) begin
      unique case (ctrl_reg.oc)
        PDC_OC_NONE: wave_next = wave_reg;
        PDC_OC_TOGGLE: wave_next = !wave_reg;
        PDC_OC_ZERO: wave_next = 1'b0;
        PDC_OC_ONE: wave_next = 1'b1;
      endcase
    end
  end

  // Sticky events: set wins over a write-one clear in the same cycle
  wire logic [6:0] ev_set = {ext_fall, wave_ev, reload_ev, (state_reg == PDC_IDLE) && timer_en,
                             psc_wrap, match_ev, timeout_ev};
  wire logic [6:0] ev_clr = (wr_en && hit_stat) ? (pwdata[6:0] & wmask[6:0]) : 7'h00;

  always_comb begin
    event_next = (event_reg & ~ev_clr) | ev_set;
  end

  // Seven conditions each gated by their own enable bit
  assign irq_req = event_reg & ctrl_reg.irq_en;
  assign waveform_out = wave_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Register writes
  wire logic [31:0] ctrl_wr = (ctrl_reg & ~wmask) | (pwdata & wmask);
  wire logic [31:0] prel_wr = ({16'h0000, first_reload_value} & ~wmask) | (pwdata & wmask);
  wire logic [31:0] match_wr = ({16'h0000, match_value_register} & ~wmask) | (pwdata & wmask);

  // Control and value registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PDC_CTRL_RST;
      first_reload_value <= `PDC_PREL_RST;
      match_value_register <= `PDC_MATCH_RST;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_reg <= ctrl_wr;
      end
      if (hit_prel) begin
        first_reload_value <= prel_wr[15:0];
      end
      if (hit_match) begin
        match_value_register <= match_wr[15:0];
      end
    end
  end

  // Timer state, flags and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PDC_IDLE;
      event_reg <= 7'h00;
      com_reg <= 1'b0;
      wave_reg <= 1'b0;
      half_clk_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      match_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      event_reg <= event_next;
      // Timeout clears the compare level even if a match coincides
      com_reg <= timeout_ev ? 1'b0 : (match_ev ? 1'b1 : com_reg);
      wave_reg <= wave_next;
      half_clk_reg <= !half_clk_reg;
      ext_prev_reg <= ext_lvl;
      match_prev_reg <= match_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, registered in the setup cycle so it is stable through access
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[6:0] = event_reg;
    status_word[`PDC_ST_COM] = com_reg;
    status_word[`PDC_ST_RUNNING] = running;
    status_word[`PDC_ST_OUT] = wave_reg;
    status_word[`PDC_ST_EXT_LVL] = ext_lvl;
  end

  assign rd_mux = hit_ctrl ? ctrl_reg :
                  hit_stat ? status_word :
                  hit_prel ? {16'h0000, first_reload_value} :
                  hit_match ? {16'h0000, match_value_register} :
                  hit_count ? {8'h00, cnt} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RESET_VALUES: assert property (@(posedge pclk) $rose(presetn) |-> (cnt.psc == 8'hFF) && (cnt.count == 16'h0000))
    else $error("prescaler or counter not at reset value");

  AST_FIRST_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    first_edge && cnt_tick && timer_en |=> cnt.count == $past(first_reload_value))
    else $error("counter not loaded on first edge after enable");

  AST_RELOAD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    timer_en && cnt_zero && cnt_tick |=> cnt.count == $past(first_reload_value))
    else $error("counter not reloaded at zero");

  AST_PSC_TICK: assert property (@(posedge pclk) disable iff (!presetn)
    psc_wrap |=> cnt.psc == 8'hFF)
    else $error("prescaler wrap not to all ones");

  AST_CHAIN: assert property (@(posedge pclk) disable iff (!presetn)
    timer_en && ctrl_reg.cnt_from_psc && !psc_wrap |-> !cnt_tick)
    else $error("chained counter advanced without prescaler wrap");

  AST_TIMEOUT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    timeout_ev |=> event_reg[`PDC_EV_TIMEOUT] && !com_reg && cnt_zero)
    else $error("timeout flags wrong");

  AST_MATCH_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    match_ev && !timeout_ev |=> event_reg[`PDC_EV_MATCH] && com_reg)
    else $error("match did not set flags");

  AST_ENABLE_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
    !(ctrl_reg.prescale_count_enable && ctrl_reg.soft_run_control) |=> (state_reg == PDC_IDLE) || timer_en)
    else $error("timer left idle without both enables");

  AST_DECREMENT: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_tick && !cnt_load && timer_en |=> cnt.count == $past(cnt.count) - 16'h0001)
    else $error("counter did not decrement by one");

  AST_WAVE_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    mode_capcmp && match_ev && ctrl_reg.oc == PDC_OC_TOGGLE |=> waveform_out != $past(waveform_out))
    else $error("compare match did not toggle output");

  AST_IRQ_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req == (event_reg & ctrl_reg.irq_en))
    else $error("interrupt condition not masked");

  AST_HALF_CLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    half_fall |=> !half_fall ##1 half_fall)
    else $error("internal clock not half rate");
endmodule

// ### testbench/pdc_host_model.sv
// APB host model and external count clock source facing the timer core
`timescale 1ns/1ps
module pdc_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Result of the last transfer
  output logic done,
  output logic chk,
  output logic [32:0] rsp,
  output logic stuck,
  // External count clock, half period in pclk cycles, 0 stops it
  input wire logic [3:0] ext_half,
  output logic ext_clk
);
  logic [3:0] ecnt;

  //////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    done = 1'b0;
    chk = 1'b0;
    rsp = 33'h0;
    stuck = 1'b0;
    ext_clk = 1'b0;
    ecnt = 4'h0;
  end

  // Clock stands low outside use, so no stray edge reaches the synchroniser
  always @(posedge pclk) begin
    if (ext_half == 4'h0) begin
      ext_clk <= 1'b0;
      ecnt <= 4'h0;
    end else if (ecnt == ext_half - 4'h1) begin
      ext_clk <= ~ext_clk;
      ecnt <= 4'h0;
    end else begin
      ecnt <= ecnt + 4'h1;
    end
  end

  // Result strobe lasts one cycle
  always @(posedge pclk) begin
    if (done) begin
      done <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One transfer: setup, then access held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic c, output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? s : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      stuck <= 1'b1;
    end
    q = prdata;
    rsp <= {pslverr, prdata};
    chk <= c;
    done <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### testbench/pdc_timer_bench.sv
// Self-checking bench for the down-counter timer core
`timescale 1ns/1ps
`include "pdc_defines.svh"
module pdc_timer_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, waveform_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, ext_half;
  logic ext_count_clock_in, done, chk, stuck;
  logic [6:0] irq_req;
  logic [32:0] rsp;
  logic [64:0] ent;
  logic [64:0] exp_q[$];
  int err_count, total_checks, cyc, p, m;

  //////////////////////////////////////////////////////////////////////////////
  // Design and its host
  pdc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_clock_in(ext_count_clock_in), .waveform_out(waveform_out), .irq_req(irq_req));
  pdc_host_model host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .done(done), .chk(chk), .rsp(rsp), .stuck(stuck), .ext_half(ext_half), .ext_clk(ext_count_clock_in));

  // 40 MHz clock and a cycle counter for period measurement
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // Monitor: oldest note against each checked read
  always @(posedge pclk) begin
    if (done && chk) begin
      total_checks++;
      if (exp_q.size() == 0) begin
        err_count++;
        $display("ERROR t=%0t exp=none got=%h", $time, rsp);
      end else begin
        ent = exp_q.pop_front();
        if ((rsp[31:0] & ent[63:32]) !== (ent[31:0] & ent[63:32]) || rsp[32] !== ent[64]) begin
          err_count++;
          $display("ERROR t=%0t exp=%h got=%h", $time, ent, rsp);
        end
      end
    end
  end

  // A hung bus ends the run
  always @(posedge stuck) begin
    err_count++;
    $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, pready);
    tally_and_finish();
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] e, input logic [31:0] a);
    total_checks++;
    if (a !== e) begin
      err_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] q;
    host.xfer(1'b1, a, d, s, 1'b0, q);
  endtask

  // Checked read; the mask picks the bits that are defined at that moment
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] k = 32'hFFFF_FFFF,
                        input logic er = 1'b0);
    logic [31:0] q;
    exp_q.push_back({er, k, e});
    host.xfer(1'b0, a, 32'h0, 4'h0, 1'b1, q);
  endtask

  // Sampled on the falling edge so the design's updates have landed
  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (irq_req[0] !== 1'b1 && n < bound);
    if (n >= bound) begin
      err_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, irq_req[0]);
      tally_and_finish();
    end
  endtask

  // Cycles between two timeout interrupts, flag cleared in between
  task automatic period(input int bound, output int r);
    int t0;
    wait_irq(bound);
    t0 = cyc;
    wr(`PDC_STAT_OFS, 32'h0000_007F);
    wait_irq(bound);
    r = cyc - t0;
  endtask

  task automatic stop_all();
    wr(`PDC_CTRL_OFS, 32'h0);
    wr(`PDC_STAT_OFS, 32'h0000_007F);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ext_half = 4'h0;
    cyc = 0;
    err_count = 0;
    total_checks = 0;
    p = $urandom(61);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`PDC_COUNT_OFS, 32'h0000_00FF);
    rd_chk(`PDC_CTRL_OFS, 32'h0);
    rd_chk(`PDC_STAT_OFS, 32'h0);
    rd_chk(12'h0FC, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(`PDC_COUNT_OFS, 32'h00AB_CD12);
    rd_chk(`PDC_COUNT_OFS, 32'h0000_00FF);
    wr(`PDC_MATCH_OFS, 32'h0000_1234, 4'h1);
    rd_chk(`PDC_MATCH_OFS, 32'h0000_0034, 32'h0000_FFFF);
    $display("test reset_and_bus done");
    // Either enable bit alone leaves the counter parked
    for (int i = 1; i < 3; i++) begin
      wr(`PDC_PREL_OFS, 32'h5);
      wr(`PDC_CTRL_OFS, 32'(i));
      repeat (20) @(posedge pclk);
      rd_chk(`PDC_COUNT_OFS, 32'h0000_00FF);
      rd_chk(`PDC_STAT_OFS, 32'h0, 32'h0000_0208);
    end
    $display("test half_enable done");
    // Half clock, compare mode driving the output high on match
    stop_all();
    p = 2 + $urandom % 6;
    wr(`PDC_PREL_OFS, 32'(p));
    wr(`PDC_MATCH_OFS, 32'h2);
    wr(`PDC_CTRL_OFS, 32'h0001_0303);
    period(64, m);
    cmp(32'(2 * (p + 1)), 32'(m));
    rd_chk(`PDC_STAT_OFS, 32'h0000_0623, 32'h0000_0723);
    cmp(32'h1, {31'h0, waveform_out});
    $display("test half_clock done");
    // External clock, six pclk per period, through the synchroniser
    stop_all();
    ext_half <= 4'h3;
    wr(`PDC_PREL_OFS, 32'h3);
    // Square mode, toggle on timeout: two toggles bring the level back to one
    wr(`PDC_CTRL_OFS, 32'h0001_0117);
    period(200, m);
    cmp(32'd24, 32'(m));
    rd_chk(`PDC_STAT_OFS, 32'h0000_0471, 32'h0000_0471);
    ext_half <= 4'h0;
    $display("test ext_clock done");
    // Prescaler chained ahead of the counter: 256 half-clock ticks per count
    stop_all();
    wr(`PDC_PREL_OFS, 32'h1);
    wr(`PDC_CTRL_OFS, 32'h0001_000B);
    period(2000, m);
    cmp(32'd1024, 32'(m));
    rd_chk(`PDC_STAT_OFS, 32'h0000_0015, 32'h0000_0015);
    stop_all();
    $display("test chained done");
    tally_and_finish();
  end
endmodule
